// ### inc/vcds_consts.svh
`ifndef VCDS_CONSTS_SVH
`define VCDS_CONSTS_SVH

// dac target counted in 6.25 mV steps
`define VCDS_STEP_UV 6250
`define VCDS_CODE_BASE 9'd258
`define VCDS_CODE_TOP 8'hb2
`define VCDS_CODE_OFF_LO 8'hfe
`define VCDS_MIN_STEPS 9'd80
`define VCDS_BOOT_STEPS 9'd176
`define VCDS_DAC_RST 9'h000

// timing, in ns as printed, and the clock period
`define VCDS_CLK_NS 100
`define VCDS_TD1_NS 1360000
`define VCDS_TD3_NS 85000
`define VCDS_TD5_NS 85000

// pin bus layout after synchronisation
`define VCDS_PIN_W 17
`define VCDS_PIN_VID_LSB 9
`define VCDS_PIN_LLI 8
`define VCDS_PIN_EN_PWR 7
`define VCDS_PIN_EN_VTT 6
`define VCDS_PIN_BIAS 5
`define VCDS_PIN_UV 4
`define VCDS_PIN_OV 3
`define VCDS_PIN_OC 2
`define VCDS_PIN_WIN 1
`define VCDS_PIN_SSOSC 0

`endif

// ### inc/vcds_pkg.sv
package vcds_pkg;

  typedef enum logic [7:0] {
    VCDS_SHUT = 8'h01,
    VCDS_DLY = 8'h02,
    VCDS_RAMP1 = 8'h04,
    VCDS_BOOT = 8'h08,
    VCDS_RAMP2 = 8'h10,
    VCDS_RDY_DLY = 8'h20,
    VCDS_RUN = 8'h40,
    VCDS_OFF = 8'h80
  } vcds_state_e;

  typedef struct packed {
    logic off;
    logic [8:0] steps;
  } vcds_dec_s;

  typedef struct packed {
    logic ocp_boost;
    logic ovp_max;
    logic phase_drop;
  } vcds_prot_s;

endpackage

// ### core/vcds_sync.sv
`timescale 1ns/100ps
module vcds_sync #(
  parameter int W = 1
) (
  // clocking
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // pins in, settled levels out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_next;

  // a bit only moves once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_out[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_out <= '0;
    end else if (clk_en) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_out <= level_next;
    end
  end

endmodule

// ### core/vcds_top.sv
// How it works
// - fixed lookup of 8-bit code to target; two top codes mean output off
// - while running, follow code changes step by step without jumps
// - raise overcurrent threshold during code transitions, upward and downward
// - overvoltage threshold goes to its maximum during code transitions
// - transition under light-load indicator forces all phases until it completes
// - soft-start begins only once both enables and bias are good
// - ready goes high only after soft-start with output in window
// - off code after boot plateau shuts down until enable or bias cycles
// - soft-start ramps move the dac one 6.25 mV step per oscillator tick
// - before ready, ignore light-load indicator and run all phases
// - ready low on uv, ov, oc, disable, reset or off code
`timescale 1ns/100ps
`include "vcds_consts.svh"
module vcds_top import vcds_pkg::*; #(
  parameter int TD1_CYC = (`VCDS_TD1_NS + `VCDS_CLK_NS - 1) / `VCDS_CLK_NS,
  parameter int TD3_CYC = (`VCDS_TD3_NS + `VCDS_CLK_NS - 1) / `VCDS_CLK_NS,
  parameter int TD5_CYC = (`VCDS_TD5_NS + `VCDS_CLK_NS - 1) / `VCDS_CLK_NS
) (
  // clocking
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // processor side
  input wire logic [7:0] voltage_select_code,
  input wire logic light_load_indicator_n,
  // enables and bias
  input wire logic en_pwr,
  input wire logic en_vtt,
  input wire logic bias_ok,
  // analog monitors and soft-start oscillator
  input wire logic uv_fault,
  input wire logic ov_fault,
  input wire logic oc_fault,
  input wire logic vout_in_window,
  input wire logic ss_osc,
  // regulator controls
  output logic [8:0] dac_target,
  output logic pwm_enable,
  output vcds_prot_s prot_ctrl,
  output logic regulator_ready_out
);

  localparam int CNT_W = 16;

  logic [`VCDS_PIN_W-1:0] pins;
  logic [7:0] code;
  logic lli_n;
  logic enabled;
  logic faults;
  logic ss_prev_reg;
  logic ss_tick;
  vcds_dec_s dec;
  vcds_state_e state_reg;
  vcds_state_e state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [8:0] dac_reg;
  logic [8:0] dac_next;
  logic trans;
  logic ready_next;
  logic pwm_next;
  vcds_prot_s prot_next;

  function automatic vcds_dec_s vcds_decode(input logic [7:0] c);
    vcds_dec_s d;
    d.off = (c >= `VCDS_CODE_OFF_LO);
    // codes past the lowest valid entry hold the lowest target
    if (c <= `VCDS_CODE_TOP) begin
      d.steps = 9'(`VCDS_CODE_BASE - {1'b0, c});
    end else begin
      d.steps = `VCDS_MIN_STEPS;
    end
    return d;
  endfunction

  // one lsb per call keeps the reference free of jumps
  function automatic logic [8:0] vcds_step(input logic [8:0] cur, input logic [8:0] tgt);
    if (cur < tgt) begin
      return 9'(cur + 9'd1);
    end else if (cur > tgt) begin
      return 9'(cur - 9'd1);
    end else begin
      return cur;
    end
  endfunction

  vcds_sync #(
    .W(`VCDS_PIN_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin_in({voltage_select_code, light_load_indicator_n, en_pwr, en_vtt, bias_ok,
             uv_fault, ov_fault, oc_fault, vout_in_window, ss_osc}),
    .level_out(pins)
  );

  assign code = pins[`VCDS_PIN_VID_LSB +: 8];
  assign lli_n = pins[`VCDS_PIN_LLI];
  assign enabled = pins[`VCDS_PIN_EN_PWR] & pins[`VCDS_PIN_EN_VTT] & pins[`VCDS_PIN_BIAS];
  assign faults = pins[`VCDS_PIN_UV] | pins[`VCDS_PIN_OV] | pins[`VCDS_PIN_OC];
  assign ss_tick = pins[`VCDS_PIN_SSOSC] & ~ss_prev_reg;
  assign dec = vcds_decode(code);

  // sequencer and dac target
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    dac_next = dac_reg;
    if (!enabled) begin
      // losing any enable or bias, or a reset, is the only way out of the off latch
      state_next = VCDS_SHUT;
      cnt_next = '0;
      dac_next = `VCDS_DAC_RST;
    end else begin
      unique case (state_reg)
        VCDS_SHUT: begin
          state_next = VCDS_DLY;
          cnt_next = '0;
        end
        VCDS_DLY: begin
          cnt_next = CNT_W'(cnt_reg + 1'b1);
          if (cnt_reg == CNT_W'(TD1_CYC - 1)) begin
            state_next = VCDS_RAMP1;
            cnt_next = '0;
          end
        end
        VCDS_RAMP1: begin
          if (dac_reg == `VCDS_BOOT_STEPS) begin
            state_next = VCDS_BOOT;
            cnt_next = '0;
          end else if (ss_tick) begin
            dac_next = vcds_step(dac_reg, `VCDS_BOOT_STEPS);
          end
        end
        VCDS_BOOT: begin
          cnt_next = CNT_W'(cnt_reg + 1'b1);
          if (cnt_reg == CNT_W'(TD3_CYC - 1)) begin
            cnt_next = '0;
            if (dec.off) begin
              state_next = VCDS_OFF;
              dac_next = `VCDS_DAC_RST;
            end else begin
              state_next = VCDS_RAMP2;
            end
          end
        end
        VCDS_RAMP2: begin
          if (dac_reg == dec.steps) begin
            state_next = VCDS_RDY_DLY;
            cnt_next = '0;
          end else if (ss_tick) begin
            dac_next = vcds_step(dac_reg, dec.steps);
          end
        end
        VCDS_RDY_DLY: begin
          cnt_next = CNT_W'(cnt_reg + 1'b1);
          if (cnt_reg == CNT_W'(TD5_CYC - 1)) begin
            state_next = VCDS_RUN;
            cnt_next = '0;
          end
        end
        VCDS_RUN: begin
          if (dec.off) begin
            state_next = VCDS_OFF;
            dac_next = `VCDS_DAC_RST;
          end else if (ss_tick) begin
            // relies on the processor pacing its code steps
            dac_next = vcds_step(dac_reg, dec.steps);
          end
        end
        VCDS_OFF: begin
          dac_next = `VCDS_DAC_RST;
        end
        default: begin
          state_next = VCDS_SHUT;
          cnt_next = '0;
          dac_next = `VCDS_DAC_RST;
        end
      endcase
    end
  end

  // protection thresholds, phase control and ready
  always_comb begin
    trans = (state_reg == VCDS_RUN) && (dac_reg != dec.steps);
    prot_next.ocp_boost = trans;
    prot_next.ovp_max = trans;
    ready_next = (state_reg == VCDS_RUN) && enabled && !dec.off && !faults
                 && pins[`VCDS_PIN_WIN];
    // any transition pins all phases; indicator counts only on the edge ready stands
    prot_next.phase_drop = ready_next && !trans && !lli_n;
    // next state, so switching stops on the same edge the dac is cleared
    pwm_next = enabled && (state_next != VCDS_SHUT) && (state_next != VCDS_DLY)
               && (state_next != VCDS_OFF);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= VCDS_SHUT;
      cnt_reg <= '0;
      dac_reg <= `VCDS_DAC_RST;
      ss_prev_reg <= 1'b0;
      dac_target <= `VCDS_DAC_RST;
      pwm_enable <= 1'b0;
      prot_ctrl <= '0;
      regulator_ready_out <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      dac_reg <= dac_next;
      ss_prev_reg <= pins[`VCDS_PIN_SSOSC];
      dac_target <= dac_next;
      pwm_enable <= pwm_next;
      prot_ctrl <= prot_next;
      regulator_ready_out <= ready_next;
    end
  end

endmodule

// ### tb/vcds_cpu.sv
`timescale 1ns/100ps
module vcds_cpu #(
  parameter int STEP_CYC = 16
) (
  // clocking
  input wire logic ref_clk,
  // bench commands
  input wire logic [7:0] goal_code,
  input wire logic low_power,
  // pins toward the regulator
  output logic [7:0] voltage_select_code,
  output logic light_load_indicator_n
);
  int cnt = 0;
  initial voltage_select_code = 8'h85;
  initial light_load_indicator_n = 1'b1;
  always @(posedge ref_clk) begin
    light_load_indicator_n <= !low_power;
    cnt <= (cnt == STEP_CYC - 1) ? 0 : cnt + 1;
    // one code step per interval, never a jump
    if (cnt == 0 && voltage_select_code != goal_code) begin
      voltage_select_code <= voltage_select_code + ((voltage_select_code < goal_code) ? 8'h01 : 8'hff);
    end
  end
endmodule

// ### tb/vcds_top_checker.sv
`timescale 1ns/100ps
module vcds_top_checker import vcds_pkg::*; (
  // clocking
  input wire logic ref_clk,
  input wire logic reset,
  // inputs
  input wire logic en_pwr,
  input wire logic uv_fault,
  // outputs
  input wire logic [8:0] dac_target,
  input wire logic pwm_enable,
  input wire vcds_prot_s prot_ctrl,
  input wire logic regulator_ready_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  rdy_needs_pwm_a: assert property (regulator_ready_out |-> pwm_enable) else $error("ready while idle");
  dac_step_a: assert property (pwm_enable && $past(pwm_enable) |->
    (dac_target == $past(dac_target)) || (dac_target - $past(dac_target) == 9'h001) ||
    ($past(dac_target) - dac_target == 9'h001)) else $error("dac jumped");
  idle_dac_a: assert property (!pwm_enable |-> dac_target == 9'h000) else $error("dac set while idle");
  boost_pair_a: assert property (prot_ctrl.ocp_boost == prot_ctrl.ovp_max) else $error("flags split");
  boost_no_drop_a: assert property (prot_ctrl.ocp_boost |-> !prot_ctrl.phase_drop) else $error("drop in step");
  drop_needs_rdy_a: assert property (prot_ctrl.phase_drop |-> regulator_ready_out) else $error("early drop");
  en_low_off_a: assert property ((!en_pwr) [*8] |=> !pwm_enable) else $error("runs while disabled");
  uv_drops_rdy_a: assert property (uv_fault [*8] |=> !regulator_ready_out) else $error("ready in fault");
endmodule
bind vcds_top vcds_top_checker u_chk (.ref_clk(ref_clk), .reset(reset), .en_pwr(en_pwr), .uv_fault(uv_fault),
  .dac_target(dac_target), .pwm_enable(pwm_enable), .prot_ctrl(prot_ctrl),
  .regulator_ready_out(regulator_ready_out));

// ### tb/vcds_top_bench.sv
`timescale 1ns/100ps
module vcds_top_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic en_pwr = 1'b0;
  logic en_vtt = 1'b0;
  logic bias_ok = 1'b0;
  logic uv_fault = 1'b0;
  logic oc_fault = 1'b0;
  logic ov_fault = 1'b0;
  logic vout_in_window = 1'b1;
  logic ss_osc = 1'b0;
  logic low_power = 1'b1;
  logic [7:0] goal_code = 8'h85;
  logic [7:0] voltage_select_code;
  logic light_load_indicator_n;
  logic [8:0] dac_target;
  logic pwm_enable;
  logic [2:0] prot_ctrl;
  logic regulator_ready_out;
  int n_errors = 0;
  int checks_done = 0;
  int ss_cnt = 0;
  int i;
  // short counts keep the run small
  vcds_top #(.TD1_CYC(20), .TD3_CYC(10), .TD5_CYC(10)) DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .voltage_select_code(voltage_select_code), .light_load_indicator_n(light_load_indicator_n),
    .en_pwr(en_pwr), .en_vtt(en_vtt), .bias_ok(bias_ok), .uv_fault(uv_fault), .ov_fault(ov_fault),
    .oc_fault(oc_fault), .vout_in_window(vout_in_window), .ss_osc(ss_osc), .dac_target(dac_target),
    .pwm_enable(pwm_enable), .prot_ctrl(prot_ctrl), .regulator_ready_out(regulator_ready_out));
  vcds_cpu cpu (.ref_clk(ref_clk), .goal_code(goal_code), .low_power(low_power),
    .voltage_select_code(voltage_select_code), .light_load_indicator_n(light_load_indicator_n));
  always #50 ref_clk = ~ref_clk;
  // ticks slow enough to survive the synchroniser
  always @(posedge ref_clk) begin
    ss_cnt <= ss_cnt + 1;
    ss_osc <= ss_cnt[2];
  end
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_dac(input logic [8:0] v, input int lim);
    for (i = 0; i < lim && dac_target !== v; i++) @(negedge ref_clk);
  endtask
  task automatic wait_pwm(input logic v, input int lim);
    for (i = 0; i < lim && pwm_enable !== v; i++) @(negedge ref_clk);
  endtask
  task automatic t_start();
    @(posedge ref_clk);
    bias_ok <= 1'b1;
    en_pwr <= 1'b1;
    repeat (100) @(negedge ref_clk);
    check("pwm gated", pwm_enable, 1'b0);
    @(posedge ref_clk);
    en_vtt <= 1'b1;
    wait_pwm(1'b1, 100);
    check("ramp start", dac_target, 9'h000);
    wait_dac(9'd176, 2000);
    check("boot level", dac_target, 9'd176);
    check("early prot", prot_ctrl, 3'b000);
    for (i = 0; i < 1000 && regulator_ready_out !== 1'b1; i++) @(negedge ref_clk);
    check("ready up", regulator_ready_out, 1'b1);
    check("run target", dac_target, 9'd125);
    repeat (3) @(negedge ref_clk);
    check("drop after ready", prot_ctrl, 3'b001);
    @(posedge ref_clk);
    low_power <= 1'b0;
    repeat (8) @(negedge ref_clk);
    check("no drop at load", prot_ctrl, 3'b000);
    @(posedge ref_clk);
    low_power <= 1'b1;
    repeat (8) @(negedge ref_clk);
    check("drop again", prot_ctrl, 3'b001);
  endtask
  task automatic t_move(input logic [7:0] code, input logic [8:0] steps);
    @(posedge ref_clk);
    goal_code <= code;
    for (i = 0; i < 400 && prot_ctrl[2] !== 1'b1; i++) @(negedge ref_clk);
    check("step flags", prot_ctrl, 3'b110);
    wait_dac(steps, 3000);
    repeat (3) @(negedge ref_clk);
    check("after step", prot_ctrl, 3'b001);
    check("step target", dac_target, steps);
  endtask
  task automatic t_fault();
    // uv, oc, ov in turn, then output out of window
    for (int f = 0; f < 4; f++) begin
      @(posedge ref_clk);
      {vout_in_window, ov_fault, oc_fault, uv_fault} <= (f == 3) ? 4'b0000 : 4'(4'b1000 | (4'b0001 << f));
      repeat (8) @(negedge ref_clk);
      check("fault ready", regulator_ready_out, 1'b0);
      @(posedge ref_clk);
      {vout_in_window, ov_fault, oc_fault, uv_fault} <= 4'b1000;
      repeat (8) @(negedge ref_clk);
      check("ready back", regulator_ready_out, 1'b1);
    end
  endtask
  task automatic t_off();
    @(posedge ref_clk);
    goal_code <= 8'hfe;
    wait_pwm(1'b0, 2000);
    repeat (100) @(negedge ref_clk);
    check("off dac", dac_target, 9'h000);
    check("off ready", regulator_ready_out, 1'b0);
    @(posedge ref_clk);
    en_pwr <= 1'b0;
    repeat (10) @(posedge ref_clk);
    en_pwr <= 1'b1;
    wait_pwm(1'b1, 100);
    check("restart", pwm_enable, 1'b1);
    wait_pwm(1'b0, 2500);
    check("off after boot", pwm_enable, 1'b0);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_start();
    t_move(8'h88, 9'd122);
    t_move(8'h86, 9'd124);
    t_move(8'hb3, 9'd80);
    t_fault();
    t_off();
    close_out();
  end
endmodule
